// file: include/modem_hs_pkg.sv
`default_nettype none

package modem_hs_pkg;

  // register byte offsets on the 8-bit bus address
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_P1_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_P1_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFS_P1_INT_ENABLE = 8'h08;
  localparam logic [7:0] OFS_P2_MODEM_CONTROL = 8'h10;
  localparam logic [7:0] OFS_P2_MODEM_STATUS = 8'h14;
  localparam logic [7:0] OFS_P2_INT_ENABLE = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;

  // modem control fields
  localparam int CTRL_TERMINAL_READY = 0;
  localparam int CTRL_REQUEST_SEND = 1;
  localparam int CTRL_LOOPBACK = 4;

  // interrupt enable field: modem status change
  localparam int IEN_MODEM_STATUS = 3;

  // modem status fields: deltas low nibble, inverted levels high nibble
  // pin order inside a nibble is {carrier, ring, set_ready, clear_send}
  localparam int STAT_DELTA_CLEAR_SEND = 0;
  localparam int STAT_DELTA_SET_READY = 1;
  localparam int STAT_DELTA_RING = 2;
  localparam int STAT_DELTA_CARRIER = 3;
  localparam int STAT_CLEAR_SEND = 4;
  localparam int STAT_SET_READY = 5;
  localparam int STAT_RING = 6;
  localparam int STAT_CARRIER = 7;

  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IEN_RESET = 8'h00;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [3:0] PINS_IDLE = 4'hF;
  localparam logic [3:0] DELTA_RESET = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // shared by the read and the write path
  function automatic logic reg_mapped(input logic [7:0] addr);
    return (addr == OFS_P1_MODEM_CONTROL) || (addr == OFS_P1_MODEM_STATUS) ||
           (addr == OFS_P1_INT_ENABLE) || (addr == OFS_P2_MODEM_CONTROL) ||
           (addr == OFS_P2_MODEM_STATUS) || (addr == OFS_P2_INT_ENABLE) ||
           (addr == OFS_INT_STATUS) || (addr == OFS_INT_MASK);
  endfunction

endpackage

`default_nettype wire

// file: design/reset_sync.sv
`default_nettype none

module reset_sync (
  // clock and raw reset
  input wire logic clock,
  input wire logic reset_n,
  // released copy
  output logic rst_n
);

  logic stage_q;
  logic out_q;

  // asserts at once, releases after two edges so release is clean
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      stage_q <= 1'b1;
      out_q <= stage_q;
    end
  end

  assign rst_n = out_q;

endmodule // reset_sync

`default_nettype wire

// file: design/modem_port.sv
`default_nettype none

module modem_port
  import modem_hs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // software control
  input wire logic [7:0] modem_control,
  input wire logic status_read,
  // modem pins {carrier, ring, set_ready, clear_send}, active low
  input wire logic [3:0] pins_n,
  output logic terminal_ready_n,
  output logic request_send_n,
  // status to software
  output logic [7:0] modem_status,
  output logic change
);

  logic [3:0] pins_q, pins_d;
  logic [3:0] delta_q, delta_d;
  logic [3:0] rise;
  logic dtr_n_q, dtr_n_d;
  logic rts_n_q, rts_n_d;
  logic change_q, change_d;
  logic loop;

  // next state: pins sampled once, deltas sticky until a status read
  always_comb
  begin
    loop = modem_control[CTRL_LOOPBACK];
    pins_d = pins_n;
    rise = pins_n & ~pins_q;
    // a rise in the reading cycle survives the clear
    delta_d = (delta_q & ~{4{status_read}}) | rise;
    change_d = |(pins_n ^ pins_q);
    dtr_n_d = ~(modem_control[CTRL_TERMINAL_READY] & ~loop);
    rts_n_d = ~(modem_control[CTRL_REQUEST_SEND] & ~loop);
  end

  // handshake outputs idle high from reset onward
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_q <= PINS_IDLE;
      delta_q <= DELTA_RESET;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      change_q <= 1'b0;
    end
    else
    begin
      pins_q <= pins_d;
      delta_q <= delta_d;
      dtr_n_q <= dtr_n_d;
      rts_n_q <= rts_n_d;
      change_q <= change_d;
    end
  end

  // levels read inverted so a one means the modem asserts the line
  assign modem_status = {~pins_q, delta_q};
  assign terminal_ready_n = dtr_n_q;
  assign request_send_n = rts_n_q;
  // clear to send only reports; no transmitter is gated by it
  assign change = change_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_ring_rise;
    !pins_n[2] ##1 pins_n[2];
  endsequence
  sequence s_cts_rise;
    !pins_n[0] ##1 pins_n[0];
  endsequence
  sequence s_dsr_rise;
    !pins_n[1] ##1 pins_n[1];
  endsequence
  sequence s_dcd_rise;
    !pins_n[3] ##1 pins_n[3];
  endsequence

  a_dtr_follows:
    assert property (modem_control[CTRL_TERMINAL_READY] && !loop |=> !terminal_ready_n)
    else $error("terminal ready not asserted from control bit");
  a_loop_idle:
    assert property (loop |=> terminal_ready_n && request_send_n)
    else $error("handshake output active in loopback");
  a_rts_follows:
    assert property (modem_control[CTRL_REQUEST_SEND] && !loop |=> !request_send_n)
    else $error("request to send not asserted from control bit");
  a_ring_level:
    assert property (!pins_n[2] |=> modem_status[STAT_RING])
    else $error("ring level not reported inverted");
  a_ring_delta:
    assert property (s_ring_rise |=> modem_status[STAT_DELTA_RING])
    else $error("ring delta not set");
  a_cts_delta:
    assert property (s_cts_rise |=> modem_status[STAT_DELTA_CLEAR_SEND])
    else $error("clear to send delta not set");
  a_dsr_delta:
    assert property (s_dsr_rise |=> modem_status[STAT_DELTA_SET_READY] &&
                     !modem_status[STAT_SET_READY])
    else $error("set ready delta or level wrong");
  a_dcd_level:
    assert property (s_dcd_rise |=> modem_status[STAT_DELTA_CARRIER] &&
                     !modem_status[STAT_CARRIER])
    else $error("carrier delta or level wrong");
  a_read_clears:
    assert property (status_read && (pins_n == pins_q) |=> modem_status[3:0] == 4'h0)
    else $error("status read left a delta set");

endmodule // modem_port

`default_nettype wire

// file: design/uart_modem_handshake.sv
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none

module uart_modem_handshake
  import modem_hs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register bus write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // register bus write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // register bus write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // register bus read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // register bus read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port 1 modem lines
  input wire logic port1_clear_send_n,
  input wire logic port1_set_ready_n,
  input wire logic port1_ring_indicate_n,
  input wire logic port1_carrier_detect_n,
  output logic port1_terminal_ready_n,
  output logic port1_request_send_n,
  // port 2 modem lines
  input wire logic port2_clear_send_n,
  input wire logic port2_set_ready_n,
  input wire logic port2_ring_indicate_n,
  input wire logic port2_carrier_detect_n,
  output logic port2_terminal_ready_n,
  output logic port2_request_send_n,
  // interrupt
  output logic irq
);

  logic rst_n;

  // write channel state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic commit;
  logic wr_en;

  // read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic ar_fire;

  // software registers
  logic [1:0][7:0] modem_control_q, modem_control_d;
  logic [1:0][7:0] int_enable_q, int_enable_d;
  logic [1:0] int_status_q, int_status_d;
  logic [1:0] int_mask_q, int_mask_d;
  logic [1:0] events;

  // port links
  logic [1:0] status_read;
  logic [1:0] change;
  logic [7:0] p1_status;
  logic [7:0] p2_status;

  // protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, wstrb[3:1]};

  reset_sync u_reset_sync (
    .clock(clock),
    .reset_n(reset_n),
    .rst_n(rst_n)
  );

  // address and data taken in either order; held until the commit cycle
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign commit = aw_held_q && w_held_q && !bvalid_q;
  // registers are one byte wide, so only lane 0 writes them
  assign wr_en = commit && wlane_q;

  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awvalid && awready)
    begin
      aw_held_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready)
    begin
      w_held_d = 1'b1;
      wdata_d = wdata;
      wlane_d = wstrb[0];
    end
    if (commit)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // a read of a status register is also the clear strobe of its deltas
  assign arready = !rvalid_q;
  assign ar_fire = arvalid && arready;
  assign status_read[0] = ar_fire && (araddr == OFS_P1_MODEM_STATUS);
  assign status_read[1] = ar_fire && (araddr == OFS_P2_MODEM_STATUS);

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFS_P1_MODEM_CONTROL: rdata_d = {24'h00_0000, modem_control_q[0]};
        OFS_P1_MODEM_STATUS: rdata_d = {24'h00_0000, p1_status};
        OFS_P1_INT_ENABLE: rdata_d = {24'h00_0000, int_enable_q[0]};
        OFS_P2_MODEM_CONTROL: rdata_d = {24'h00_0000, modem_control_q[1]};
        OFS_P2_MODEM_STATUS: rdata_d = {24'h00_0000, p2_status};
        OFS_P2_INT_ENABLE: rdata_d = {24'h00_0000, int_enable_q[1]};
        OFS_INT_STATUS: rdata_d = {30'h0000_0000, int_status_q};
        OFS_INT_MASK: rdata_d = {30'h0000_0000, int_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    else if (rvalid_q && rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // software registers; an event in the clearing cycle stays pending
  always_comb
  begin
    modem_control_d = modem_control_q;
    int_enable_d = int_enable_q;
    int_mask_d = int_mask_q;
    int_status_d = int_status_q;
    events[0] = change[0] && int_enable_q[0][IEN_MODEM_STATUS];
    events[1] = change[1] && int_enable_q[1][IEN_MODEM_STATUS];
    if (wr_en)
    begin
      case (waddr_q)
        OFS_P1_MODEM_CONTROL: modem_control_d[0] = wdata_q[7:0];
        OFS_P1_INT_ENABLE: int_enable_d[0] = wdata_q[7:0];
        OFS_P2_MODEM_CONTROL: modem_control_d[1] = wdata_q[7:0];
        OFS_P2_INT_ENABLE: int_enable_d[1] = wdata_q[7:0];
        OFS_INT_STATUS: int_status_d = int_status_q & ~wdata_q[1:0];
        OFS_INT_MASK: int_mask_d = wdata_q[1:0];
        default: int_mask_d = int_mask_q;
      endcase
    end
    int_status_d = int_status_d | events;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modem_control_q <= {CTRL_RESET, CTRL_RESET};
      int_enable_q <= {IEN_RESET, IEN_RESET};
      int_mask_q <= INT_RESET;
      int_status_q <= INT_RESET;
    end
    else
    begin
      modem_control_q <= modem_control_d;
      int_enable_q <= int_enable_d;
      int_mask_q <= int_mask_d;
      int_status_q <= int_status_d;
    end
  end

  // level output, high while any unmasked pending bit stands
  assign irq = |(int_status_q & int_mask_q);

  modem_port u_port1 (
    .clock(clock),
    .rst_n(rst_n),
    .modem_control(modem_control_q[0]),
    .status_read(status_read[0]),
    .pins_n({port1_carrier_detect_n, port1_ring_indicate_n,
             port1_set_ready_n, port1_clear_send_n}),
    .terminal_ready_n(port1_terminal_ready_n),
    .request_send_n(port1_request_send_n),
    .modem_status(p1_status),
    .change(change[0])
  );

  // second port is the same logic with its own registers
  modem_port u_port2 (
    .clock(clock),
    .rst_n(rst_n),
    .modem_control(modem_control_q[1]),
    .status_read(status_read[1]),
    .pins_n({port2_carrier_detect_n, port2_ring_indicate_n,
             port2_set_ready_n, port2_clear_send_n}),
    .terminal_ready_n(port2_terminal_ready_n),
    .request_send_n(port2_request_send_n),
    .modem_status(p2_status),
    .change(change[1])
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_p2_ring_rise;
    !port2_ring_indicate_n ##1 port2_ring_indicate_n;
  endsequence
  sequence s_p1_event;
    change[0] && int_enable_q[0][IEN_MODEM_STATUS] && int_mask_q[0];
  endsequence

  a_reset_idle:
    assert property ($rose(rst_n) |-> port1_terminal_ready_n && port2_terminal_ready_n)
    else $error("terminal ready active at reset release");
  a_irq_raise:
    assert property (s_p1_event |=> irq [*2])
    else $error("enabled modem change gave no interrupt");
  a_irq_quiet:
    assert property (!int_enable_q[0][IEN_MODEM_STATUS] && !int_status_q[0] &&
                     !wr_en |=> !int_status_q[0])
    else $error("disabled modem change set interrupt");
  a_port2_ring:
    assert property (s_p2_ring_rise |=> p2_status[STAT_DELTA_RING])
    else $error("second port ring delta not set");
  a_port2_rts:
    assert property (modem_control_q[1][CTRL_LOOPBACK] |=> port2_request_send_n &&
                     port2_terminal_ready_n)
    else $error("second port output active in loopback");
  a_port2_cts:
    assert property (!port2_clear_send_n |=> p2_status[STAT_CLEAR_SEND])
    else $error("second port clear send level wrong");

endmodule // uart_modem_handshake

`default_nettype wire

// file: tb/modem_model.sv
`default_nettype none

module modem_model (
  // clock
  input wire logic clock,
  // wanted line levels and pace
  input wire logic [3:0] target,
  input wire logic slow,
  // modem lines {carrier, ring, set_ready, clear_send}, active low
  output logic [3:0] pins_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  initial pins_n = 4'hF;
  initial wait_q = 2'h0;
  // a slow modem settles its lines three cycles late, so the bench never relies on one edge
  always @(posedge clock)
  begin
    if (pins_n == target)
      wait_q <= 2'h0;
    else if (!slow || wait_q == 2'h3)
      pins_n <= target;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule // modem_model

`default_nettype wire

// file: tb/tb_uart_modem_handshake.sv
`default_nettype none

module tb_uart_modem_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_hs_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, t1 = 4'hF, t2 = 4'hF, p1, p2, old, nv;
  logic awready, wready, bvalid, arready, rvalid, irq, dtr1_n, rts1_n, dtr2_n, rts2_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [33:0] exp_r;
  logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
  logic [7:0] ctl[6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h13, 8'h11};
  logic [7:0] c_ofs, s_ofs, e_ofs;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0, check_count = 0, cycles = 0, p, i, k;
  int seed = 32'hc1f6;

  uart_modem_handshake uart_modem_handshake_i (.clock(clock), .reset_n(reset_n),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port1_clear_send_n(p1[0]), .port1_set_ready_n(p1[1]), .port1_ring_indicate_n(p1[2]),
    .port1_carrier_detect_n(p1[3]), .port1_terminal_ready_n(dtr1_n),
    .port1_request_send_n(rts1_n),
    .port2_clear_send_n(p2[0]), .port2_set_ready_n(p2[1]), .port2_ring_indicate_n(p2[2]),
    .port2_carrier_detect_n(p2[3]), .port2_terminal_ready_n(dtr2_n),
    .port2_request_send_n(rts2_n), .irq(irq));
  modem_model modem_model_i (.clock(clock), .target(t1), .slow(slow), .pins_n(p1));
  modem_model modem_model_i2 (.clock(clock), .target(t2), .slow(slow), .pins_n(p2));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask

  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge clock);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // read: expected word noted first, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clock);
    rq.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // the model may be slow, so give the lines time to settle before any read
  task automatic setpins(input int q, input logic [3:0] x);
    if (q == 1)
      t2 <= x;
    else
      t1 <= x;
    repeat (8) @(posedge clock);
  endtask

  // monitor: each answer on the bus is held against the oldest note
  always @(posedge clock)
  begin
    if (rvalid && rready)
    begin
      exp_r = rq.pop_front();
      chk("rdata", exp_r[31:0], rdata);
      chk("rresp", {30'h0, exp_r[33:32]}, {30'h0, rresp});
    end
    if (bvalid && bready)
      chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end

  // hang guard, far above the well under a thousand cycles the sequence needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("outs", 32'hF, {28'h0, dtr1_n, rts1_n, dtr2_n, rts2_n});
    chk("irq", 32'h0, {31'h0, irq});
    chk("ready", 32'h7, {29'h0, awready, wready, arready});
    for (i = 0; i < 8; i++)
      rd(ofs[i], 8'h00, RESP_OKAY);
    for (p = 0; p < 2; p++)
    begin
      c_ofs = p ? OFS_P2_MODEM_CONTROL : OFS_P1_MODEM_CONTROL;
      s_ofs = p ? OFS_P2_MODEM_STATUS : OFS_P1_MODEM_STATUS;
      e_ofs = p ? OFS_P2_INT_ENABLE : OFS_P1_INT_ENABLE;
      for (i = 0; i < 6; i++)
      begin
        wr(c_ofs, ctl[i], 4'hF, RESP_OKAY);
        repeat (2) @(posedge clock);
        chk("dtr", {31'h0, !(ctl[i][0] && !ctl[i][4])}, {31'h0, p ? dtr2_n : dtr1_n});
        chk("rts", {31'h0, !(ctl[i][1] && !ctl[i][4])}, {31'h0, p ? rts2_n : rts1_n});
      end
      wr(c_ofs, 8'h03, 4'hE, RESP_OKAY);
      rd(c_ofs, 8'h11, RESP_OKAY);
      for (i = 0; i < 4; i++)
      begin
        setpins(p, ~(4'h1 << i));
        rd(s_ofs, {4'h1 << i, 4'h0}, RESP_OKAY);
        setpins(p, 4'hF);
        rd(s_ofs, {4'h0, 4'h1 << i}, RESP_OKAY);
        rd(s_ofs, 8'h00, RESP_OKAY);
      end
      old = 4'hF;
      for (k = 0; k < 9; k++)
      begin
        v = $random(seed);
        nv = (k == 8) ? 4'hF : v[3:0];
        slow <= v[4];
        setpins(p, nv);
        rd(s_ofs, {~nv, ~old & nv}, RESP_OKAY);
        old = nv;
      end
      wr(OFS_INT_MASK, 8'h01 << p, 4'hF, RESP_OKAY);
      wr(e_ofs, 8'h08, 4'hF, RESP_OKAY);
      setpins(p, p ? 4'hB : 4'hE);
      chk("irq", 32'h1, {31'h0, irq});
      rd(OFS_INT_STATUS, 8'h01 << p, RESP_OKAY);
      wr(OFS_INT_MASK, 8'h00, 4'hF, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
      wr(OFS_INT_STATUS, 8'h01 << p, 4'hF, RESP_OKAY);
      rd(OFS_INT_STATUS, 8'h00, RESP_OKAY);
      wr(e_ofs, 8'h00, 4'hF, RESP_OKAY);
      setpins(p, 4'hF);
      rd(OFS_INT_STATUS, 8'h00, RESP_OKAY);
      rd(s_ofs, p ? 8'h04 : 8'h01, RESP_OKAY);
      wr(OFS_INT_MASK, 8'h01 << p, 4'hF, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
    end
    rd(8'h0C, 8'h00, RESP_SLVERR);
    wr(8'h0C, 8'hFF, 4'hF, RESP_SLVERR);
    repeat (4) @(posedge clock);
    chk("pending", 32'h0, rq.size() + bq.size());
    results();
  end
endmodule // tb_uart_modem_handshake

`default_nettype wire
